/* verilog/msi_map_pkg.sv */
// Constants and types shared by the interrupt source tag mapper
package msi_map_pkg;
  localparam int TAG_W        = 32;
  localparam int STREAM_W     = 32;
  localparam int RID_W        = 16;
  localparam int GROUP_W      = 4;
  localparam int TARGET_W     = 4;
  localparam logic [TAG_W-1:0] RID_SPAN = 32'h0001_0000;
  localparam logic [TAG_W-1:0] OFFSET_A_RST = 32'h0000_0000;
  localparam logic [TAG_W-1:0] OFFSET_C_RST = 32'h0000_0000;
  localparam logic [TAG_W-1:0] POISON_TAG_RST = 32'hFFFF_FFFF;

  typedef enum logic [1:0] {
    SRC_STREAM  = 2'h0,
    SRC_RID     = 2'h1,
    SRC_DIRECT  = 2'h2,
    SRC_ILLEGAL = 2'h3
  } src_kind_t;

  typedef enum logic [1:0] {
    POL_IGNORE = 2'h0,
    POL_ABORT  = 2'h1,
    POL_POISON = 2'h2
  } ill_policy_t;
endpackage : msi_map_pkg

/* verilog/msi_source_id_mapper.sv */
// Source device tag mapper and illegal interrupt write policer
`timescale 1ns/1ps

// How it works
// R01: Every accepted interrupt write leaves with a source device tag attached.
// R02: Writes from a processing element or an untrusted non-interrupt master never carry another device's tag.
// R03: A write whose target translation unit lies outside the requester's group is illegal.
// R04: An illegal write is ignored, aborted, or forwarded with a tag no legitimate source uses.
// R05: The stream tag from the io translation unit is passed through unchanged alongside the tag, except one built by a root complex behind it (R08).
// R06: Stream tag to source tag is one-to-one because it is a pure addition modulo the tag width.
// R07: Behind the io translation unit the tag is the zero-extended stream tag plus offset A.
// R08: A root complex behind the translation unit forms its stream tag as RequesterID plus 0x10000 times constant B.
// R09: A root complex without a translation unit forms the tag as RequesterID plus 0x10000 times constant C.
// R10: Any other identifier maps by identity plus a constant offset.
// R11: Loaded offsets freeze once initialization is signalled done.
// R12: Tags for empty slots are reserved by the offsets, so a later device finds its tag already set.
// R13: A hot-plugged device takes its tag from the same static mapping with nothing new created.
// R14: Directly attached masters get a unique tag per group through the same offset scheme.
// R15: The tag does not depend on which translation unit of a group is targeted.
// R16: Offsets come from parameters at reset or are loaded, as often as needed, before initialization ends.
module msi_source_id_mapper
  import msi_map_pkg::*;
#(
  parameter logic [TAG_W-1:0] OFFSET_B = 32'h0000_0000
) (
  input  wire logic                sys_clk,
  input  wire logic                rst_n,
  input  wire logic                cfgLoad,
  input  wire logic [TAG_W-1:0]    cfgOffsetA,
  input  wire logic [TAG_W-1:0]    cfgOffsetC,
  input  wire logic [1:0]          cfgPolicy,
  input  wire logic                initDone,
  input  wire logic                reqValid,
  input  wire src_kind_t           reqKind,
  input  wire logic                reqRcBehindIotu,
  input  wire logic [STREAM_W-1:0] reqStreamTag,
  input  wire logic [RID_W-1:0]    reqRequesterId,
  input  wire logic [GROUP_W-1:0]  reqGroup,
  input  wire logic [GROUP_W-1:0]  reqTargetGroup,
  input  wire logic                reqTrusted,
  output logic                     outValid,
  output logic [TAG_W-1:0]         outSourceTag,
  output logic [STREAM_W-1:0]      outStreamTag,
  output logic                     outAbort,
  output logic                     outIllegal,
  output logic                     cfgLocked
);
  // Zero-extension and the span product both assume these limits; refuse anything else
  if (STREAM_W > TAG_W) begin : gen_stream_too_wide
    $error("stream tag wider than source tag");
  end
  if (RID_W > STREAM_W) begin : gen_rid_too_wide
    $error("requester id wider than stream tag");
  end
  if ((OFFSET_B * RID_SPAN) / RID_SPAN != OFFSET_B) begin : gen_offset_b_wraps
    $error("constant B wraps the stream tag");
  end

  // Configuration state, loaded before init and frozen after
  logic [TAG_W-1:0]    offA_reg;
  logic [TAG_W-1:0]    offA_next;
  logic [TAG_W-1:0]    offC_reg;
  logic [TAG_W-1:0]    offC_next;
  ill_policy_t         pol_reg;
  ill_policy_t         pol_next;
  logic                lock_reg;
  logic                lock_next;
  // Answer registers; every output but cfgLocked is one of these
  logic                vld_reg;
  logic                vld_next;
  logic                abt_reg;
  logic                abt_next;
  logic                ill_reg;
  logic                ill_next;
  logic [TAG_W-1:0]    tag_reg;
  logic [TAG_W-1:0]    tag_next;
  logic [STREAM_W-1:0] sid_reg;
  logic [STREAM_W-1:0] sid_next;
  // Terms of the mapping functions
  logic [STREAM_W-1:0] rcStream;
  logic [STREAM_W-1:0] fwdStream;
  logic [TAG_W-1:0]    streamTag;
  logic [TAG_W-1:0]    ridTag;
  logic [TAG_W-1:0]    otherTag;
  logic                crossGroup;
  logic                illegal;

  // Offset registers; loads after init are dropped so the map stays static
  always_comb begin
    offA_next = offA_reg;
    offC_next = offC_reg;
    pol_next  = pol_reg;
    lock_next = lock_reg | initDone; // [R11]
    if (cfgLoad && !lock_reg) begin // [R11] [R16]
      offA_next = cfgOffsetA;
      offC_next = cfgOffsetC;
      pol_next  = (cfgPolicy == 2'h3) ? POL_POISON : ill_policy_t'(cfgPolicy);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      offA_reg <= OFFSET_A_RST;
      offC_reg <= OFFSET_C_RST;
      pol_reg  <= POL_IGNORE;
      lock_reg <= 1'b0;
    end else begin
      offA_reg <= offA_next;
      offC_reg <= offC_next;
      pol_reg  <= pol_next;
      lock_reg <= lock_next;
    end
  end

  // Stream tag for a root complex behind the translation unit; B is fixed at build time
  assign rcStream = STREAM_W'(TAG_W'(reqRequesterId) + RID_SPAN * OFFSET_B); // [R08]

  // Stream tag that leaves with the write: untouched unless a root complex built it
  assign fwdStream = reqRcBehindIotu ? rcStream : reqStreamTag; // [R05] [R08]

  // Each mapping is an addition modulo the tag width, hence one-to-one
  assign streamTag = TAG_W'(fwdStream) + offA_reg; // [R06] [R07] [R15]
  assign ridTag    = TAG_W'(reqRequesterId) + RID_SPAN * offC_reg; // [R09] [R13]
  assign otherTag  = TAG_W'(reqStreamTag) + offA_reg; // [R10] [R12] [R14]

  // Target group deliberately not used for the tag, only for legality
  assign crossGroup = (reqGroup != reqTargetGroup); // [R03]
  assign illegal    = (reqKind == SRC_ILLEGAL) || !reqTrusted || crossGroup; // [R02] [R03]

  always_comb begin
    vld_next = 1'b0;
    abt_next = 1'b0;
    ill_next = 1'b0;
    tag_next = tag_reg;
    sid_next = sid_reg;
    if (reqValid) begin
      if (illegal) begin
        ill_next = 1'b1;
        unique case (pol_reg) // [R04]
          POL_IGNORE: ;
          POL_ABORT:  abt_next = 1'b1;
          POL_POISON: begin
            // Offsets must keep every real tag clear of this value, or poison could alias a source
            vld_next = 1'b1;
            tag_next = POISON_TAG_RST; // [R02]
            sid_next = reqStreamTag;
          end
          // Code 3 is folded into poison on load, so this arm only guards a corrupt register
          default: ;
        endcase
      end else begin
        vld_next = 1'b1; // [R01]
        unique case (reqKind)
          SRC_STREAM: begin
            sid_next = fwdStream; // [R05] [R08]
            tag_next = streamTag; // [R07]
          end
          SRC_RID: begin
            sid_next = reqStreamTag;
            tag_next = ridTag; // [R09]
          end
          SRC_DIRECT: begin
            sid_next = reqStreamTag;
            tag_next = otherTag; // [R10]
          end
          // Kind 3 is always illegal and never reaches this branch
          default: begin
            sid_next = reqStreamTag;
            tag_next = otherTag;
          end
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      vld_reg <= 1'b0;
      abt_reg <= 1'b0;
      ill_reg <= 1'b0;
      tag_reg <= '0;
      sid_reg <= '0;
    end else begin
      vld_reg <= vld_next;
      abt_reg <= abt_next;
      ill_reg <= ill_next;
      tag_reg <= tag_next;
      sid_reg <= sid_next;
    end
  end

  assign outValid     = vld_reg;
  assign outSourceTag = tag_reg;
  assign outStreamTag = sid_reg;
  assign outAbort     = abt_reg;
  assign outIllegal   = ill_reg;
  assign cfgLocked    = lock_reg;

  // Mapping checks; offsets are taken from the request cycle, since a load may land in between
  stream_map_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R07]
    reqValid && !illegal && reqKind == SRC_STREAM && !reqRcBehindIotu
    |=> outValid && outSourceTag == TAG_W'($past(reqStreamTag)) + $past(offA_reg))
    else $error("stream tag map wrong");

  // Downstream logic relies on the stream tag arriving unchanged
  pass_stream_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R05]
    reqValid && !illegal && reqKind == SRC_STREAM && !reqRcBehindIotu |=> outStreamTag == $past(reqStreamTag))
    else $error("stream tag altered");

  pass_other_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R05]
    reqValid && !illegal && reqKind != SRC_STREAM |=> outStreamTag == $past(reqStreamTag))
    else $error("stream tag altered on other kinds");

  // The root complex constant lands above the requester id in the forwarded stream tag
  rc_stream_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R08]
    reqValid && !illegal && reqKind == SRC_STREAM && reqRcBehindIotu
    |=> outStreamTag == STREAM_W'(TAG_W'($past(reqRequesterId)) + RID_SPAN * OFFSET_B)
        && outSourceTag == TAG_W'(outStreamTag) + $past(offA_reg))
    else $error("root complex stream tag wrong");

  rc_direct_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R09]
    reqValid && !illegal && reqKind == SRC_RID
    |=> outSourceTag == TAG_W'($past(reqRequesterId)) + RID_SPAN * $past(offC_reg))
    else $error("requester map wrong");

  other_id_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R10]
    reqValid && !illegal && reqKind == SRC_DIRECT
    |=> outValid && outSourceTag == TAG_W'($past(reqStreamTag)) + $past(offA_reg))
    else $error("other id map wrong");

  // Back-to-back stream requests with different stream tags must not share a source tag
  one_to_one_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R06]
    reqValid && !illegal && reqKind == SRC_STREAM
    ##1 reqValid && !illegal && reqKind == SRC_STREAM && fwdStream != $past(fwdStream) && $stable(offA_reg)
    |=> outSourceTag != $past(outSourceTag))
    else $error("two stream tags share a source tag");

  // Legality: every illegal write is flagged and never leaves with a real tag
  group_check_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R03]
    reqValid && reqGroup != reqTargetGroup |=> outIllegal)
    else $error("cross group write not flagged");

  untrusted_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R02]
    reqValid && !reqTrusted |=> outIllegal)
    else $error("untrusted write accepted");

  pe_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R02]
    reqValid && reqKind == SRC_ILLEGAL |=> outIllegal && (!outValid || outSourceTag == POISON_TAG_RST))
    else $error("processing element write accepted");

  no_alias_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R02]
    outIllegal && outValid |-> outSourceTag == POISON_TAG_RST)
    else $error("illegal write carries real tag");

  // Policy is taken from the request cycle for the same reason as the offsets
  ill_handle_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R04]
    reqValid && illegal
    |=> outIllegal && (outAbort == ($past(pol_reg) == POL_ABORT))
        && (outValid == ($past(pol_reg) == POL_POISON)))
    else $error("illegal handling wrong");

  // An abort never also forwards, so the far side cannot see a refused write
  abort_alone_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R04]
    outAbort |-> outIllegal && !outValid)
    else $error("aborted write forwarded");

  // Answer framing
  legal_tag_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R01]
    reqValid && !illegal |=> outValid && !outIllegal && !outAbort)
    else $error("legal write dropped");

  idle_quiet_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R01]
    !reqValid |=> !outValid && !outAbort && !outIllegal)
    else $error("answer without request");

  // Tags hold between forwarded writes; the first cycle after reset is skipped for a one-edge reset
  tag_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R01]
    !outValid && $past(rst_n) |-> $stable(outSourceTag) && $stable(outStreamTag))
    else $error("tag moved without a write");

  // Configuration
  lock_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R11]
    initDone |=> cfgLocked)
    else $error("init done did not lock the map");

  map_frozen_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R11]
    lock_reg |=> $stable(offA_reg) && $stable(offC_reg) && $stable(pol_reg) && lock_reg)
    else $error("offsets changed after init");

  load_apply_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R16]
    cfgLoad && !lock_reg |=> offA_reg == $past(cfgOffsetA) && offC_reg == $past(cfgOffsetC))
    else $error("offset load lost");

  policy_code_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R04]
    cfgLoad && !lock_reg && cfgPolicy == 2'h3 |=> pol_reg == POL_POISON)
    else $error("spare policy code not poison");

  // Main scenarios
  cover_stream_c: cover property (@(posedge sys_clk) reqValid && !illegal && reqKind == SRC_STREAM);
  cover_rid_c:    cover property (@(posedge sys_clk) reqValid && !illegal && reqKind == SRC_RID);
  cover_abort_c:  cover property (@(posedge sys_clk) outAbort);
  cover_poison_c: cover property (@(posedge sys_clk) outIllegal && outValid);
  cover_lock_c:   cover property (@(posedge sys_clk) cfgLocked && cfgLoad);
endmodule : msi_source_id_mapper

/* tb/msi_sink_model.sv */
// Interrupt translation unit stand-in that counts forwarded writes
`timescale 1ns/1ps
module msi_sink_model (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        outValid,
  input  wire logic [31:0] outSourceTag,
  output int               fwdCount,
  output logic [31:0]      lastTag
);
  // Accepts every forwarded write at once; it never back-pressures the mapper
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      fwdCount <= 0;
      lastTag  <= 32'h0000_0000;
    end else if (outValid) begin
      fwdCount <= fwdCount + 1;
      lastTag  <= outSourceTag;
    end
  end
endmodule : msi_sink_model

/* tb/msi_source_id_mapper_tb_top.sv */
// Self-checking bench for the interrupt source tag mapper
`timescale 1ns/1ps
module msi_source_id_mapper_tb_top
  import msi_map_pkg::*;
;
  logic sys_clk = 1'b0, rst_n = 1'b0, cfgLoad = 1'b0, initDone = 1'b0, reqValid = 1'b0, reqRc = 1'b0, reqTrusted = 1'b1;
  logic [31:0] cfgA = 32'h0, cfgC = 32'h0, reqStream = 32'h0, tag, oStream, lastTag;
  logic [1:0]  cfgPolicy = 2'h0;
  src_kind_t   reqKind = SRC_STREAM;
  logic [15:0] reqRid = 16'h0;
  logic [3:0]  reqGroup = 4'h0, reqTarget = 4'h0;
  logic        oValid, oAbort, oIllegal, locked;
  int          mismatches = 0, nCompared = 0, fwdCount;
  always #4 sys_clk = ~sys_clk;
  msi_source_id_mapper #(.OFFSET_B(32'h0000_0002)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .cfgLoad(cfgLoad),
    .cfgOffsetA(cfgA), .cfgOffsetC(cfgC), .cfgPolicy(cfgPolicy), .initDone(initDone), .reqValid(reqValid),
    .reqKind(reqKind), .reqRcBehindIotu(reqRc), .reqStreamTag(reqStream), .reqRequesterId(reqRid),
    .reqGroup(reqGroup), .reqTargetGroup(reqTarget), .reqTrusted(reqTrusted), .outValid(oValid),
    .outSourceTag(tag), .outStreamTag(oStream), .outAbort(oAbort), .outIllegal(oIllegal), .cfgLocked(locked));
  msi_sink_model sink (.sys_clk(sys_clk), .rst_n(rst_n), .outValid(oValid), .outSourceTag(tag),
    .fwdCount(fwdCount), .lastTag(lastTag));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cfg(input logic [31:0] a, input logic [31:0] c, input logic [1:0] p);
    @(posedge sys_clk);
    cfgLoad <= 1'b1; cfgA <= a; cfgC <= c; cfgPolicy <= p;
    @(posedge sys_clk);
    cfgLoad <= 1'b0;
  endtask : cfg
  // One request, then the one-cycle answer is judged after its edge settles
  task automatic req(input logic [1:0] k, input logic rc, input logic [31:0] s, input logic [15:0] rid,
                     input logic [3:0] tg, input logic tr, input logic [2:0] vai, input logic [31:0] eTag,
                     input logic [31:0] eStream);
    @(posedge sys_clk);
    reqValid <= 1'b1; reqKind <= src_kind_t'(k); reqRc <= rc; reqStream <= s; reqRid <= rid;
    reqGroup <= 4'h1; reqTarget <= tg; reqTrusted <= tr;
    @(posedge sys_clk);
    reqValid <= 1'b0;
    #1;
    chk({29'h0, oValid, oAbort, oIllegal}, {29'h0, vai});
    if (vai[2]) chk(tag, eTag);
    if (vai[2] && eStream !== 32'hFFFF_FFFF) chk(oStream, eStream);
  endtask : req
  task automatic legal_maps();
    cfg(32'h0000_0100, 32'h0000_0003, 2'h0);
    req(2'h0, 1'b0, 32'h0000_0005, 16'h0, 4'h1, 1'b1, 3'h4, 32'h0000_0105, 32'h0000_0005);
    req(2'h0, 1'b0, 32'hFFFF_FF00, 16'h0, 4'h1, 1'b1, 3'h4, 32'h0000_0000, 32'hFFFF_FF00);
    req(2'h0, 1'b1, 32'h0, 16'h1234, 4'h1, 1'b1, 3'h4, 32'h0002_1334, 32'h0002_1234);
    req(2'h1, 1'b0, 32'h0, 16'hFFFF, 4'h1, 1'b1, 3'h4, 32'h0003_FFFF, 32'hFFFF_FFFF);
    req(2'h2, 1'b0, 32'h0000_0007, 16'h0, 4'h1, 1'b1, 3'h4, 32'h0000_0107, 32'hFFFF_FFFF);
  endtask : legal_maps
  task automatic illegal_writes();
    req(2'h0, 1'b0, 32'h0000_0005, 16'h0, 4'h2, 1'b1, 3'h1, 32'h0, 32'h0);
    for (int p = 0; p < 4; p++) begin
      cfg(32'h0000_0100, 32'h0000_0003, p[1:0]);
      req(2'h3, 1'b0, 32'h0000_0005, 16'h0, 4'h1, 1'b1, p[1] ? 3'h5 : (p[0] ? 3'h3 : 3'h1),
          32'hFFFF_FFFF, 32'hFFFF_FFFF);
    end
    cfg(32'h0000_0100, 32'h0000_0003, 2'h1);
    req(2'h0, 1'b0, 32'h0000_0005, 16'h0, 4'h1, 1'b0, 3'h3, 32'h0, 32'h0);
  endtask : illegal_writes
  task automatic lock_check();
    cfg(32'h0000_0100, 32'h0000_0003, 2'h0);
    @(posedge sys_clk);
    initDone <= 1'b1;
    @(posedge sys_clk);
    initDone <= 1'b0;
    cfg(32'h0000_0500, 32'h0000_0009, 2'h1);
    #1;
    chk({31'h0, locked}, 32'h1);
    req(2'h0, 1'b0, 32'h0000_0005, 16'h0, 4'h1, 1'b1, 3'h4, 32'h0000_0105, 32'h0000_0005);
    req(2'h0, 1'b0, 32'h0000_0005, 16'h0, 4'h2, 1'b1, 3'h1, 32'h0, 32'h0);
    chk(fwdCount, 32'h8);
    chk(lastTag, 32'h0000_0105);
  endtask : lock_check
  task automatic summarize();
    if (mismatches == 0 && nCompared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  initial begin
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    legal_maps();
    illegal_writes();
    lock_check();
    summarize();
  end
  // Whole sequence needs well under 200 cycles
  initial begin
    #20000;
    mismatches++;
    summarize();
  end
endmodule : msi_source_id_mapper_tb_top
